// >>> design/twsmc_top.sv
// Purpose: byte-oriented two-wire serial unit, master and slave, Wishbone registers
// Assumes: SCL and SDA are open-drain, synchronised here; one status code per event
// Notes:   bit rate = CLK / (divider * CLK_PER_DIV) in master modes
//
// Overview of operation
// - rate select bits only set the clock in master modes.
// - begin_request starts a START as soon as the bus is free.
// - after a START the event flag rises with status 08H.
// - transfers wait while the event flag is set, resume when cleared.
// - address write phase ends with status 18H, 20H or 38H.
// - address read phase ends with status 40H, 48H or 38H.
// - with ack_assert set, 68H, 78H or B0H may follow address phase.
// - after repeated START 10H, direction bit picks receiver or transmitter.
// - transfers never change unit_enable or rate select bits.
// - upper seven bits of own_address_reg are the slave address.
// - general_call_enable decides whether address 00H is answered.
// - own address with write bit enters slave receiver, raises event.
// - arbitration loss may drop into slave receiver with 68H or 78H.
// - ack_assert clear gives not-acknowledge after the next data byte.
// - ack_assert clear ignores own and general call addresses, keeps monitoring.
// - ack_assert clear means no slave entry when another master wins.
// - seven-bit address, eight-bit data, read high, acknowledge low.
// - event flag stretches low clock level only, never a high level.
// - status register low three bits zero; F8H raises no event.
// - halt_request in master sends STOP; hardware clears it on STOP.
`timescale 1ns/1ps
module twsmc_top #(
  parameter int CLK_PER_DIV = 8
) (
  // system
  input  wire logic        CLK,
  input  wire logic        RST,
  // wishbone slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [11:0] WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK,
  // two-wire pins
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE
);

  if (CLK_PER_DIV < 2 || CLK_PER_DIV > 256) begin : g_chk
    $error("CLK_PER_DIV out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  twsmc_pkg::twsmc_ctrl_type  ctrl;
  twsmc_pkg::twsmc_ctrl_type  next_ctrl;
  twsmc_pkg::twsmc_state_type st;
  logic [7:0]  own;
  logic [7:0]  shreg;
  logic [7:0]  code;
  logic [7:0]  rd_data;
  logic [15:0] mcnt;
  logic [15:0] half;
  logic [3:0]  bitcnt;
  logic [1:0]  step;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_prev;
  logic        sda_prev;
  logic        busy;
  logic        mst;
  logic        tx;
  logic        addr;
  logic        dir;
  logic        arb;
  logic        hit;
  logic        gen;
  logic        addressed;
  logic        rel;
  logic        ackbit;
  logic        m_scl_low;
  logic        sda_low;
  logic        ev_set;
  logic        halt_clr;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire       wb_req  = WB_CYC & WB_STB & !WB_ACK;
  wire [9:0] idx     = WB_ADR[11:2];
  // writes land on the edge at which the master samples ack
  wire       wr      = WB_CYC & WB_STB & WB_ACK & WB_WE & WB_SEL[0];
  wire       wr_ctrl = wr & (idx == twsmc_pkg::IDX_CTRL);
  wire       wr_data = wr & (idx == twsmc_pkg::IDX_DATA);
  wire       wr_adr  = wr & (idx == twsmc_pkg::IDX_ADR);
  // unmapped offsets read zero, writes to them are dropped
  assign rd_data = (idx == twsmc_pkg::IDX_CTRL) ? ctrl :
                   (idx == twsmc_pkg::IDX_STAT) ? code :
                   (idx == twsmc_pkg::IDX_DATA) ? shreg :
                   (idx == twsmc_pkg::IDX_ADR)  ? own : 8'h00;

  always_ff @(posedge CLK) begin
    if (RST) begin
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK <= wb_req;
      if (wb_req) begin
        WB_DAT_O <= {24'h00_0000, rd_data};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and line conditions
  wire scl       = scl_sync[1];
  wire sda       = sda_sync[1];
  wire scl_rise  = scl & !scl_prev;
  wire scl_fall  = !scl & scl_prev;
  wire start_det = scl & scl_prev & sda_prev & !sda;
  wire stop_det  = scl & scl_prev & !sda_prev & sda;

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      busy     <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], SCL_I};
      sda_sync <= {sda_sync[0], SDA_I};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers written by software
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = twsmc_pkg::twsmc_ctrl_type'(WB_DAT_I[7:0]);
    end
    // a hardware set wins over a clear in the same cycle
    next_ctrl.transfer_event_flag = ev_set |
      (ctrl.transfer_event_flag & !(wr_ctrl & !WB_DAT_I[3]));
    if (halt_clr & !(wr_ctrl & WB_DAT_I[4])) begin
      next_ctrl.halt_request = 1'b0;
    end
  end

  // unit_enable and rate bits follow software writes only
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= twsmc_pkg::twsmc_ctrl_type'(twsmc_pkg::CTRL_RST);
      own  <= twsmc_pkg::ADR_RST;
    end else begin
      ctrl <= next_ctrl;
      if (wr_adr) begin
        own <= WB_DAT_I[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decisions of the bit engine
  wire [2:0] rate = {ctrl.rate2, ctrl.rate1, ctrl.rate0};
  // half a bit period; only the master clock and START/STOP timing read it
  assign half = 16'((16'(twsmc_pkg::RATE_DIV[rate]) * 16'(CLK_PER_DIV)) >> 1);
  wire half_done = (mcnt >= half);
  wire ack_in    = !ackbit;
  wire own_hit   = (shreg[7:1] == own[7:1]);
  wire gc_hit    = (shreg[7:1] == 7'h00) & own[0] & !shreg[0];
  wire slv_ack   = ctrl.ack_assert & !mst & (own_hit | gc_hit);
  wire data_ack  = ctrl.ack_assert & (mst | addressed) & !tx;
  wire ack_now   = addr ? slv_ack : data_ack;
  wire end_quiet = !mst & addr & !hit & !arb;
  wire slv_str   = (st == twsmc_pkg::ST_HOLD) & !mst & (code != twsmc_pkg::C_A0);

  wire [7:0] m_code = addr ? (dir ? (ack_in ? twsmc_pkg::C_40 : twsmc_pkg::C_48)
                                  : (ack_in ? twsmc_pkg::C_18 : twsmc_pkg::C_20))
                    : tx ? (ack_in ? twsmc_pkg::C_28 : twsmc_pkg::C_30)
                         : (ack_in ? twsmc_pkg::C_50 : twsmc_pkg::C_58);
  // arbitration loss reports 38H, or the slave codes when addressed meanwhile
  wire [7:0] s_addr = !hit ? twsmc_pkg::C_38
                    : arb ? (shreg[0] ? twsmc_pkg::C_B0
                                      : (gen ? twsmc_pkg::C_78 : twsmc_pkg::C_68))
                    : (shreg[0] ? twsmc_pkg::C_A8
                                : (gen ? twsmc_pkg::C_70 : twsmc_pkg::C_60));
  wire [7:0] s_data = (arb & !addressed) ? twsmc_pkg::C_38
                    : tx ? (!ack_in ? twsmc_pkg::C_C0
                           : (ctrl.ack_assert ? twsmc_pkg::C_B8 : twsmc_pkg::C_C8))
                    : gen ? (ack_in ? twsmc_pkg::C_90 : twsmc_pkg::C_98)
                          : (ack_in ? twsmc_pkg::C_80 : twsmc_pkg::C_88);
  wire [7:0] s_code = addr ? s_addr : s_data;
  wire       s_rel  = (s_code == twsmc_pkg::C_88) | (s_code == twsmc_pkg::C_98) |
                      (s_code == twsmc_pkg::C_C0) | (s_code == twsmc_pkg::C_C8) |
                      (s_code == twsmc_pkg::C_38);

  ////////////////////////////////////////////////////////////////////////////
  // control sequencer and bit engine
  always_ff @(posedge CLK) begin
    if (RST) begin
      st        <= twsmc_pkg::ST_IDLE;
      shreg     <= twsmc_pkg::DATA_RST;
      code      <= twsmc_pkg::C_F8;
      {mcnt, bitcnt, step} <= 22'h00_0000;
      {mst, tx, addr, dir, arb, hit, gen, addressed, rel} <= 9'h000;
      {ackbit, m_scl_low, sda_low, ev_set, halt_clr} <= 5'h00;
    end else begin
      ev_set   <= 1'b0;
      halt_clr <= stop_det & ctrl.halt_request;
      if (wr_data) begin
        shreg <= WB_DAT_I[7:0];
      end
      if (!ctrl.unit_enable) begin
        st        <= twsmc_pkg::ST_IDLE;
        mst       <= 1'b0;
        m_scl_low <= 1'b0;
        sda_low   <= 1'b0;
      end else begin
        case (st)
          twsmc_pkg::ST_IDLE: begin
            mcnt <= 16'h0000;
            step <= 2'h1;
            if (ctrl.begin_request & !busy & !ctrl.transfer_event_flag) begin
              st <= twsmc_pkg::ST_START;
            end else if (start_det) begin
              st        <= twsmc_pkg::ST_XFER;
              // bitcnt parks at all ones: the clock fall closing START wraps it to zero
              {tx, addressed, bitcnt} <= 6'h0f;
              addr      <= 1'b1;
            end
          end
          twsmc_pkg::ST_START: begin
            mcnt <= mcnt + 16'h0001;
            if (step == 2'h0 && half_done) begin
              m_scl_low <= 1'b0;
              step      <= 2'h1;
              mcnt      <= 16'h0000;
            end else if (step == 2'h1 && !scl) begin
              mcnt <= 16'h0000;
            end else if (step == 2'h1 && half_done) begin
              sda_low <= 1'b1;
              step    <= 2'h2;
              mcnt    <= 16'h0000;
            end else if (step == 2'h2 && half_done) begin
              m_scl_low <= 1'b1;
              {mst, tx, addr} <= 3'h7;
              {arb, bitcnt}   <= 5'h00;
              ev_set    <= 1'b1;
              st        <= twsmc_pkg::ST_HOLD;
              code      <= mst ? twsmc_pkg::C_10 : twsmc_pkg::C_08;
            end
          end
          twsmc_pkg::ST_XFER: begin
            if (mst) begin
              if (m_scl_low) begin
                mcnt <= half_done ? 16'h0000 : mcnt + 16'h0001;
                m_scl_low <= !half_done;
              end else if (!scl) begin
                mcnt <= 16'h0000; // a slave is stretching, wait for it
              end else begin
                mcnt <= half_done ? 16'h0000 : mcnt + 16'h0001;
                m_scl_low <= half_done;
              end
            end
            if (scl_rise) begin
              if (bitcnt < twsmc_pkg::LAST_BIT) begin
                shreg <= {shreg[6:0], sda};
                if (mst & tx & shreg[7] & !sda) begin
                  {mst, tx, m_scl_low} <= 3'h0;
                  arb <= 1'b1;
                end
              end else begin
                ackbit <= sda;
              end
            end
            if (scl_fall) begin
              if (bitcnt == twsmc_pkg::LAST_BIT) begin
                {bitcnt, addr, sda_low} <= 6'h00;
                if (end_quiet) begin
                  st <= twsmc_pkg::ST_IDLE;
                end else begin
                  st     <= twsmc_pkg::ST_HOLD;
                  ev_set <= 1'b1;
                  code   <= mst ? m_code : s_code;
                  rel    <= !mst & s_rel;
                  arb    <= 1'b0;
                  if (!mst & addr & hit) begin
                    addressed <= 1'b1;
                    tx        <= shreg[0];
                  end
                  if (mst & addr) begin
                    tx <= !dir;
                  end
                end
              end else begin
                bitcnt  <= bitcnt + 4'h1;
                sda_low <= (bitcnt == 4'h7) ? (!tx & ack_now) : (tx & !shreg[7]);
                if (bitcnt == 4'h7 && addr) begin
                  hit <= slv_ack;
                  gen <= gc_hit;
                end
              end
            end
            if (!mst & start_det) begin
              {tx, addressed, bitcnt, sda_low} <= 7'h1e;
              addr <= 1'b1;
            end else if (!mst & stop_det) begin
              sda_low <= 1'b0;
              if (addressed & !tx) begin
                st     <= twsmc_pkg::ST_HOLD;
                ev_set <= 1'b1;
                code   <= twsmc_pkg::C_A0;
                rel    <= 1'b1;
              end else begin
                st <= twsmc_pkg::ST_IDLE;
              end
            end
          end
          twsmc_pkg::ST_HOLD: begin
            mcnt <= 16'h0000;
            if (!ctrl.transfer_event_flag & !ev_set) begin
              code <= twsmc_pkg::C_F8;
              if (mst & ctrl.halt_request) begin
                st      <= twsmc_pkg::ST_STOP;
                step    <= 2'h0;
                sda_low <= 1'b1;
              end else if (mst & ctrl.begin_request) begin
                st      <= twsmc_pkg::ST_START;
                step    <= 2'h0;
                sda_low <= 1'b0;
              end else if (!mst & (ctrl.halt_request | rel)) begin
                st        <= twsmc_pkg::ST_IDLE;
                {addressed, tx, rel} <= 3'h0;
                halt_clr  <= ctrl.halt_request;
              end else begin
                st      <= twsmc_pkg::ST_XFER;
                sda_low <= tx & !shreg[7];
                if (mst & addr) begin
                  dir <= shreg[0];
                end
              end
            end
          end
          twsmc_pkg::ST_STOP: begin
            mcnt <= mcnt + 16'h0001;
            if (step == 2'h0 && half_done) begin
              m_scl_low <= 1'b0;
              step      <= 2'h1;
              mcnt      <= 16'h0000;
            end else if (step == 2'h1 && !scl) begin
              mcnt <= 16'h0000;
            end else if (step == 2'h1 && half_done) begin
              sda_low <= 1'b0;
              mst     <= 1'b0;
              st      <= twsmc_pkg::ST_IDLE;
            end
          end
          default: st <= twsmc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // slave stretch starts only after a falling edge, so a high level is untouched
  assign SCL_OE = m_scl_low | slv_str;
  assign SDA_OE = sda_low;
  assign SCL_O  = 1'b0;
  assign SDA_O  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_start_code: assert property (
    (st == twsmc_pkg::ST_START && step == 2'h2 && half_done && !mst && ctrl.unit_enable)
    |=> (code == twsmc_pkg::C_08) ##1 ctrl.transfer_event_flag)
    else $error("start did not report 08H");
  chk_busy_wait: assert property (
    (st == twsmc_pkg::ST_IDLE && busy) |=> st != twsmc_pkg::ST_START)
    else $error("start issued on a busy bus");
  chk_hold_frozen: assert property (
    (st == twsmc_pkg::ST_HOLD && ctrl.transfer_event_flag && ctrl.unit_enable)
    |=> st == twsmc_pkg::ST_HOLD)
    else $error("transfer resumed while event flag set");
  chk_write_codes: assert property (
    (st == twsmc_pkg::ST_XFER && scl_fall && mst && addr && !dir && bitcnt == 4'h8)
    |=> (code == twsmc_pkg::C_18 || code == twsmc_pkg::C_20))
    else $error("bad code after write address");
  chk_read_codes: assert property (
    (st == twsmc_pkg::ST_XFER && scl_fall && mst && addr && dir && bitcnt == 4'h8)
    |=> (code == twsmc_pkg::C_40 || code == twsmc_pkg::C_48))
    else $error("bad code after read address");
  chk_ctrl_stable: assert property (
    !wr_ctrl |=> $stable({ctrl.unit_enable, rate}))
    else $error("enable or rate changed without a write");
  chk_own_ack: assert property (
    (st == twsmc_pkg::ST_XFER && scl_fall && addr && bitcnt == 4'h7 && !mst &&
     ctrl.ack_assert && shreg[7:1] == own[7:1]) |=> sda_low)
    else $error("own address not acknowledged");
  chk_gc_ignore: assert property (
    (st == twsmc_pkg::ST_XFER && scl_fall && addr && bitcnt == 4'h7 &&
     shreg == 8'h00 && !own[0] && own[7:1] != 7'h00) |=> !sda_low)
    else $error("general call answered while disabled");
  chk_addr_ignore: assert property (
    (st == twsmc_pkg::ST_XFER && scl_fall && addr && bitcnt == 4'h7 && !ctrl.ack_assert)
    |=> !sda_low)
    else $error("address answered with ack_assert clear");
  chk_data_nack: assert property (
    (st == twsmc_pkg::ST_XFER && scl_fall && !addr && !tx && bitcnt == 4'h7 &&
     !ctrl.ack_assert) |=> !sda_low)
    else $error("data acknowledged with ack_assert clear");
  chk_stretch_low: assert property (
    $rose(slv_str) |-> !scl)
    else $error("stretch began on a high clock");
  chk_code_low: assert property (
    ev_set |-> (code != twsmc_pkg::C_F8 && code[2:0] == 3'h0))
    else $error("event raised with invalid code");
  chk_halt_clear: assert property (
    (stop_det && ctrl.halt_request && !wr_ctrl) ##1 !wr_ctrl |=> !ctrl.halt_request)
    else $error("halt_request not cleared after stop");

  cov_start: cover property (ev_set && code == twsmc_pkg::C_08);
  cov_slave_rx: cover property (ev_set && code == twsmc_pkg::C_60);
  cov_data_tx: cover property (ev_set && code == twsmc_pkg::C_28);
  cov_stop: cover property (st == twsmc_pkg::ST_STOP ##[1:1000] stop_det);

endmodule

// >>> pkg/twsmc_pkg.sv
// Purpose: shared constants and types of the two-wire serial unit
// Assumes: registers are one aligned Wishbone word each, byte address = index * 4
// Notes:   status codes keep their three low bits at zero
package twsmc_pkg;

  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h0d8;
  localparam logic [9:0] IDX_STAT = 10'h0d9;
  localparam logic [9:0] IDX_DATA = 10'h0da;
  localparam logic [9:0] IDX_ADR  = 10'h0db;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADR_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;

  // status codes
  localparam logic [7:0] C_08 = 8'h08;
  localparam logic [7:0] C_10 = 8'h10;
  localparam logic [7:0] C_18 = 8'h18;
  localparam logic [7:0] C_20 = 8'h20;
  localparam logic [7:0] C_28 = 8'h28;
  localparam logic [7:0] C_30 = 8'h30;
  localparam logic [7:0] C_38 = 8'h38;
  localparam logic [7:0] C_40 = 8'h40;
  localparam logic [7:0] C_48 = 8'h48;
  localparam logic [7:0] C_50 = 8'h50;
  localparam logic [7:0] C_58 = 8'h58;
  localparam logic [7:0] C_60 = 8'h60;
  localparam logic [7:0] C_68 = 8'h68;
  localparam logic [7:0] C_70 = 8'h70;
  localparam logic [7:0] C_78 = 8'h78;
  localparam logic [7:0] C_80 = 8'h80;
  localparam logic [7:0] C_88 = 8'h88;
  localparam logic [7:0] C_90 = 8'h90;
  localparam logic [7:0] C_98 = 8'h98;
  localparam logic [7:0] C_A0 = 8'ha0;
  localparam logic [7:0] C_A8 = 8'ha8;
  localparam logic [7:0] C_B0 = 8'hb0;
  localparam logic [7:0] C_B8 = 8'hb8;
  localparam logic [7:0] C_C0 = 8'hc0;
  localparam logic [7:0] C_C8 = 8'hc8;
  localparam logic [7:0] C_F8 = 8'hf8;

  // bit rate dividers indexed by rate select, entry 7 has no timer source here
  localparam logic [7:0][7:0] RATE_DIV = {8'h30, 8'h1e, 8'h3c, 8'h30,
                                          8'h50, 8'h60, 8'h70, 8'h80};
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef struct packed {
    logic rate2;
    logic unit_enable;
    logic begin_request;
    logic halt_request;
    logic transfer_event_flag;
    logic ack_assert;
    logic rate1;
    logic rate0;
  } twsmc_ctrl_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_XFER  = 3'b010,
    ST_HOLD  = 3'b011,
    ST_STOP  = 3'b100
  } twsmc_state_type;

endpackage

// >>> testbench/twsmc_peer.sv
// Purpose: far side of the two-wire link, one slave and one master
// Assumes: open-drain lines resolved with pull-ups in the testbench
// Notes:   the slave answers the address byte only
`timescale 1ns/1ps
module twsmc_peer #(
  parameter logic [6:0] DEV_ADR = 7'h50
) (
  // resolved lines
  input  wire logic scl,
  input  wire logic sda,
  // pull-down enables
  output logic      scl_oe,
  output logic      sda_oe
);
  logic [7:0] shift;
  int         count  = 10;
  logic       ack_oe = 1'b0;
  logic       m_scl  = 1'b0;
  logic       m_sda  = 1'b0;
  assign scl_oe = m_scl;
  assign sda_oe = m_sda | ack_oe;
  ////////////////////////////////////////
  // a start restarts the byte count
  always @(negedge sda) if (scl) count = 0;
  always @(posedge scl) if (count < 8) begin
    shift = {shift[6:0], sda};
    count++;
  end
  // ack changes only at scl falling edges, so no false start or stop
  always @(negedge scl) begin
    if (count == 8) begin
      ack_oe <= (shift[7:1] == DEV_ADR);
      count = 9;
    end else if (count == 9) begin
      ack_oe <= 1'b0;
      count = 10;
    end
  end
  // master: 125 ns bit, waits out any stretch of the low phase
  task automatic drive_bit(input logic b, output logic seen);
    m_sda = !b;
    #31;
    m_scl = 1'b0;
    wait (scl === 1'b1);
    #62.5;
    seen = sda;
    m_scl = 1'b1;
    #31.5;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic unused;
    m_sda = 1'b1;
    #62.5;
    m_scl = 1'b1;
    #31.5;
    for (int i = 7; i >= 0; i--) drive_bit(b[i], unused);
    drive_bit(1'b1, ack);
  endtask
  task automatic stop();
    m_sda = 1'b1;
    #62.5;
    m_scl = 1'b0;
    #62.5;
    m_sda = 1'b0;
    #62.5;
  endtask
endmodule

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the two-wire serial unit
// Assumes: CLK_PER_DIV shortened to 2 so a bit takes 60 cycles
// Notes:   each transfer ends with a reset and a stop from the peer
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] A_CTRL = {twsmc_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {twsmc_pkg::IDX_STAT, 2'b00};
  localparam logic [11:0] A_DATA = {twsmc_pkg::IDX_DATA, 2'b00};
  localparam logic [11:0] A_ADR  = {twsmc_pkg::IDX_ADR, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [3:0]  sel = 4'h1;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack, scl_oe, sda_oe, scl_o, sda_o, p_scl_oe, p_sda_oe, pack;
  logic [7:0]  rd;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  wire         scl_line = !((scl_oe & !scl_o) | p_scl_oe);
  wire         sda_line = !((sda_oe & !sda_o) | p_sda_oe);
  twsmc_top #(.CLK_PER_DIV(2)) i_twsmc_top (.CLK(clk), .RST(rst), .WB_CYC(cyc),
    .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat_w),
    .WB_DAT_O(dat_r), .WB_ACK(ack), .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe));
  twsmc_peer i_twsmc_peer (.scl(scl_line), .sda(sda_line), .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe));
  ////////////////////////////////////////
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      $display("MISMATCH run length expected finish seen hang");
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h0, d};
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 4'h1);
    check(name, exp, rd);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tail();
    do_reset();
    i_twsmc_peer.stop();
  endtask
  task automatic wait_flag();
    do wb(1'b0, A_CTRL, 8'h00, 4'h1); while (rd[3] !== 1'b1);
  endtask
  // master address phase, rate select 6
  task automatic mcase(input logic [7:0] ab, input logic [7:0] code, input logic halt);
    wb(1'b1, A_CTRL, 8'hc2, 4'h1);
    wb(1'b1, A_CTRL, 8'he2, 4'h1);
    wait_flag();
    rdchk("start code", A_STAT, twsmc_pkg::C_08);
    wb(1'b1, A_DATA, ab, 4'h1);
    wb(1'b1, A_CTRL, 8'hc2, 4'h1);
    wait_flag();
    rdchk("address code", A_STAT, code);
    rdchk("control kept", A_CTRL, 8'hca);
    repeat (200) @(posedge clk);
    check("clock stretch", 8'h01, {7'h0, scl_oe});
    rdchk("code held", A_STAT, code);
    if (halt) begin
      wb(1'b1, A_CTRL, 8'hd2, 4'h1);
      do wb(1'b0, A_CTRL, 8'h00, 4'h1); while (rd[4] !== 1'b0);
      rdchk("idle code", A_STAT, twsmc_pkg::C_F8);
    end else begin
      wb(1'b1, A_CTRL, 8'he2, 4'h1);
      wait_flag();
      rdchk("restart code", A_STAT, twsmc_pkg::C_10);
    end
    tail();
  endtask
  // peer master addresses the unit
  task automatic scase(input logic [7:0] av, input logic [7:0] cv, input logic [7:0] b,
                       input logic eack, input logic [7:0] code);
    wb(1'b1, A_ADR, av, 4'h1);
    wb(1'b1, A_CTRL, cv, 4'h1);
    i_twsmc_peer.send(b, pack);
    check("address ack", {7'h0, eack}, {7'h0, pack});
    repeat (20) @(posedge clk);
    rdchk("slave code", A_STAT, code);
    tail();
  endtask
  initial begin
    do_reset();
    rdchk("control reset", A_CTRL, 8'h00);
    rdchk("status reset", A_STAT, twsmc_pkg::C_F8);
    wb(1'b1, A_STAT, 8'h00, 4'h1);
    rdchk("status read only", A_STAT, twsmc_pkg::C_F8);
    wb(1'b1, A_DATA, 8'h12, 4'h0);
    rdchk("data lane off", A_DATA, 8'hff);
    rdchk("address reset", A_ADR, 8'h00);
    rdchk("unmapped", 12'h000, 8'h00);
    mcase(8'ha0, twsmc_pkg::C_18, 1'b1);
    mcase(8'ha2, twsmc_pkg::C_20, 1'b0);
    mcase(8'ha1, twsmc_pkg::C_40, 1'b0);
    scase(8'h52, 8'hc7, 8'h52, 1'b0, twsmc_pkg::C_60);
    scase(8'h52, 8'h40, 8'h52, 1'b1, twsmc_pkg::C_F8);
    scase(8'h53, 8'h44, 8'h00, 1'b0, twsmc_pkg::C_70);
    scase(8'h52, 8'h44, 8'h00, 1'b1, twsmc_pkg::C_F8);
    final_report();
  end
endmodule
